// ===== key_switch_reset_defs.vh
// constants shared by the key switch reset and retention control block
`ifndef KEY_SWITCH_RESET_DEFS_VH
`define KEY_SWITCH_RESET_DEFS_VH
// clock and timing
`define CLK_HZ 25000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define GESTURE_TIME_MS 1500
`define DEBOUNCE_TIME_MS 10
`define FLASH_TIME_MS 500
`define HWRST_CYCLES 8'h10
`define CNT_W 26
// debounced key position codes
`define POS_NONE 2'h0
`define POS_REMOTE 2'h1
`define POS_RUN 2'h2
`define POS_PROGRAM 2'h3
// data area mask bits
`define AREA_G 0
`define AREA_M 1
`define AREA_I 2
`define AREA_Q 3
`define AREA_R 4
`define AREA_S 5
`define AREA_ALL 6'h3f
`define AREA_NO_S 6'h1f
`define AREA_NO_R 6'h2f
`define AREA_COPY 6'h1f
`define AREA_NONE 6'h00
// register byte offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_PROG_TIME 8'h0c
`define REG_IO_TIME 8'h10
`define REG_RED_TIME 8'h14
`define REG_TASK_CYCLE 8'h18
`define REG_IRQ_STATUS 8'h1c
`define REG_IRQ_CLEAR 8'h20
`define REG_IRQ_ENABLE 8'h24
// command register bits
`define CMD_RESET 0
`define CMD_COLD 1
`define CMD_WARM 2
`define CMD_CLEAR 3
// event bits in interrupt registers
`define EV_HWRESET 0
`define EV_FACTORY 1
`define EV_OVERRUN 2
`define EV_BATTERY 3
`define EV_POWERUP 4
`define EV_W 5
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== key_debounce.v
// synchronises and debounces a group of slow input pins
`timescale 1ns/1ns
`default_nettype none
`include "key_switch_reset_defs.vh"
module key_debounce #(
   parameter WIDTH = 5,
   parameter [`CNT_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_TIME_MS * `CYC_PER_MS
) (
   input wire clk,
   input wire rst,
   input wire [WIDTH-1:0] pinIn,
   output wire [WIDTH-1:0] stableOut
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         reg stable_q;
         reg [`CNT_W-1:0] count_q;
         // first flop feeds only the second one
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= pinIn[i];
               sync_q <= meta_q;
            end
         end
         // level must hold for the whole window before it is believed
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               stable_q <= 1'b0;
               count_q <= {`CNT_W{1'b0}};
            end else if (sync_q == stable_q) begin
               count_q <= {`CNT_W{1'b0}};
            end else if (count_q >= DEBOUNCE_CYCLES - 1'b1) begin
               stable_q <= sync_q;
               count_q <= {`CNT_W{1'b0}};
            end else begin
               count_q <= count_q + 1'b1;
            end
         end
         assign stableOut[i] = stable_q;
      end
   endgenerate
endmodule // key_debounce
`default_nettype wire

// ===== lamp_flasher.v
// one single flash of the update and battery lamps, then a done pulse
`timescale 1ns/1ns
`default_nettype none
`include "key_switch_reset_defs.vh"
module lamp_flasher #(
   parameter [`CNT_W-1:0] FLASH_CYCLES = `FLASH_TIME_MS * `CYC_PER_MS
) (
   input wire clk,
   input wire rst,
   input wire start,
   output reg lampOn,
   output reg done
);
   reg [`CNT_W-1:0] count_q;
   // lamps lit for one window only, so the flash happens exactly once
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lampOn <= 1'b0;
         done <= 1'b0;
         count_q <= {`CNT_W{1'b0}};
      end else begin
         done <= 1'b0;
         if (start && !lampOn) begin
            lampOn <= 1'b1;
            count_q <= {`CNT_W{1'b0}};
         end else if (lampOn) begin
            if (count_q >= FLASH_CYCLES - 1'b1) begin
               lampOn <= 1'b0;
               done <= 1'b1;
            end else begin
               count_q <= count_q + 1'b1;
            end
         end
      end
   end
endmodule // lamp_flasher
`default_nettype wire

// ===== key_switch_reset_control.v
// key switch gestures, reset commands, retention and redundancy control
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "key_switch_reset_defs.vh"
module key_switch_reset_control #(
   parameter [`CNT_W-1:0] GESTURE_CYCLES = `GESTURE_TIME_MS * `CYC_PER_MS,
   parameter [`CNT_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_TIME_MS * `CYC_PER_MS,
   parameter [`CNT_W-1:0] FLASH_CYCLES = `FLASH_TIME_MS * `CYC_PER_MS
) (
   input wire clk,
   input wire rst,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire remotePosition,
   input wire runPosition,
   input wire programPosition,
   input wire batteryLowPin,
   input wire isMasterPin,
   output reg localHwReset,
   output reg mastershipRelease,
   output reg [5:0] areaInit,
   output reg retainRestore,
   output reg storageErase,
   output reg userFilesErase,
   output reg [5:0] copyAreas,
   output reg redundancyCopyEn,
   output reg updateLamp,
   output reg batteryLamp,
   output reg faultLamp,
   output reg cpuFault,
   output wire irq
);
   // gesture states, one hot
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_AWAY1 = 5'h02;
   localparam [4:0] ST_BACK1 = 5'h04;
   localparam [4:0] ST_AWAY2 = 5'h08;
   localparam [4:0] ST_WAIT = 5'h10;

   wire [4:0] pinStable;
   wire flashOn;
   wire flashDone;
   reg [1:0] keyPos;
   reg [1:0] lastPos_q;
   reg [4:0] state_q;
   reg wantProgram_q;
   reg [`CNT_W-1:0] gestTimer_q;
   reg hwGesture;
   reg factoryGesture;
   reg [7:0] rstCount_q;
   reg restartPending_q;
   reg powerUp_q;
   reg redEnable_q;
   reg [15:0] progTime_q;
   reg [15:0] ioTime_q;
   reg [15:0] redTime_q;
   reg [15:0] taskCycle_q;
   reg overrun_q;
   reg batteryPrev_q;
   reg [`EV_W-1:0] irqStatus_q;
   reg [`EV_W-1:0] irqEnable_q;
   reg [`EV_W-1:0] events;
   reg [`EV_W-1:0] irqClear;
   reg [31:0] awAddr_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   reg awHave_q;
   reg wHave_q;
   reg [3:0] cmdPulse;
   wire doWrite;
   wire [17:0] loadSum;

   // applies the two low byte enables to a 16-bit time register
   function [15:0] mergeBytes;
      input [15:0] oldVal;
      input [31:0] newVal;
      input [3:0] strb;
      integer b;
      begin
         mergeBytes = oldVal;
         for (b = 0; b < 2; b = b + 1) begin
            if (strb[b]) begin
               mergeBytes[b*8 +: 8] = newVal[b*8 +: 8];
            end
         end
      end
   endfunction

   // true for every offset that the register map decodes
   function isMapped;
      input [7:0] addr;
      begin
         case (addr)
            `REG_CTRL, `REG_CMD, `REG_STATUS, `REG_PROG_TIME, `REG_IO_TIME,
            `REG_RED_TIME, `REG_TASK_CYCLE, `REG_IRQ_STATUS, `REG_IRQ_CLEAR,
            `REG_IRQ_ENABLE: isMapped = 1'b1;
            default: isMapped = 1'b0;
         endcase
      end
   endfunction

   // all pins cross two flops and a debounce window first
   key_debounce #(
      .WIDTH(5),
      .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk(clk),
      .rst(rst),
      .pinIn({isMasterPin, batteryLowPin, programPosition, runPosition,
         remotePosition}),
      .stableOut(pinStable)
   );

   // lamp flash before the factory restart
   lamp_flasher #(
      .FLASH_CYCLES(FLASH_CYCLES)
   ) u_flasher (
      .clk(clk),
      .rst(rst),
      .start(factoryGesture),
      .lampOn(flashOn),
      .done(flashDone)
   );

   // contacts between positions read as no position and are ignored
   always @* begin
      case (pinStable[2:0])
         3'h1: keyPos = `POS_REMOTE;
         3'h2: keyPos = `POS_RUN;
         3'h4: keyPos = `POS_PROGRAM;
         default: keyPos = `POS_NONE;
      endcase
   end

   // gesture detector; one gesture at a time, timer from first move
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_WAIT;
         lastPos_q <= `POS_NONE;
         wantProgram_q <= 1'b0;
         gestTimer_q <= {`CNT_W{1'b0}};
         hwGesture <= 1'b0;
         factoryGesture <= 1'b0;
      end else begin
         hwGesture <= 1'b0;
         factoryGesture <= 1'b0;
         if (keyPos != `POS_NONE) begin
            lastPos_q <= keyPos;
         end
         if (state_q != ST_IDLE && state_q != ST_WAIT) begin
            gestTimer_q <= gestTimer_q + 1'b1;
         end
         case (state_q)
            ST_IDLE: begin
               gestTimer_q <= {`CNT_W{1'b0}};
               if (keyPos == `POS_RUN || keyPos == `POS_PROGRAM) begin
                  wantProgram_q <= (keyPos == `POS_PROGRAM);
                  state_q <= ST_AWAY1;
               end
            end
            ST_AWAY1, ST_BACK1, ST_AWAY2: begin
               if (gestTimer_q >= GESTURE_CYCLES - 1'b1) begin
                  state_q <= ST_WAIT;
               end else if (keyPos != `POS_NONE && keyPos != lastPos_q) begin
                  if (keyPos == `POS_REMOTE && state_q == ST_AWAY1) begin
                     state_q <= ST_BACK1;
                  end else if (keyPos == `POS_REMOTE) begin
                     state_q <= ST_IDLE;
                     hwGesture <= !wantProgram_q;
                     factoryGesture <= wantProgram_q;
                  end else if (state_q == ST_BACK1 &&
                        (keyPos == `POS_PROGRAM) == wantProgram_q) begin
                     state_q <= ST_AWAY2;
                  end else begin
                     state_q <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (keyPos == `POS_REMOTE) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_WAIT;
         endcase
      end
   end

   // commands are refused while the key sits in run
   always @* begin
      cmdPulse = 4'h0;
      if (doWrite && awAddr_q[7:0] == `REG_CMD && wStrb_q[0] &&
            keyPos != `POS_RUN) begin
         cmdPulse = wData_q[3:0];
      end
   end

   // area initialisation and erase pulses, sources merged per cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         areaInit <= `AREA_NONE;
         retainRestore <= 1'b0;
         storageErase <= 1'b0;
         userFilesErase <= 1'b0;
         powerUp_q <= 1'b0;
      end else begin
         powerUp_q <= 1'b1;
         retainRestore <= !powerUp_q;
         storageErase <= cmdPulse[`CMD_CLEAR];
         userFilesErase <= factoryGesture;
         areaInit <= (!powerUp_q ? `AREA_NO_R : `AREA_NONE)
            | (cmdPulse[`CMD_RESET] ? `AREA_NO_R : `AREA_NONE)
            | (cmdPulse[`CMD_COLD] ? `AREA_ALL : `AREA_NONE)
            | (cmdPulse[`CMD_CLEAR] ? `AREA_ALL : `AREA_NONE)
            | (factoryGesture ? `AREA_ALL : `AREA_NONE)
            | ((keyPos == `POS_RUN && lastPos_q != `POS_RUN) ?
               `AREA_NO_S : `AREA_NONE);
         // a warm reset forces areaInit to none that cycle, dropping every other source, so all data stays as it was
         if (cmdPulse[`CMD_WARM]) begin
            areaInit <= areaInit & `AREA_NONE;
         end
      end
   end

   // local hardware reset; the partner frame never sees it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         localHwReset <= 1'b0;
         rstCount_q <= 8'h00;
         restartPending_q <= 1'b0;
         mastershipRelease <= 1'b0;
      end else begin
         mastershipRelease <= 1'b0;
         if (factoryGesture) begin
            restartPending_q <= 1'b1;
         end
         if (hwGesture || (restartPending_q && flashDone)) begin
            restartPending_q <= 1'b0;
            localHwReset <= 1'b1;
            rstCount_q <= 8'h00;
            mastershipRelease <= pinStable[4];
         end else if (localHwReset) begin
            if (rstCount_q >= `HWRST_CYCLES - 8'h01) begin
               localHwReset <= 1'b0;
            end else begin
               rstCount_q <= rstCount_q + 8'h01;
            end
         end
      end
   end

   assign loadSum = {2'h0, progTime_q} + {2'h0, ioTime_q} + {2'h0, redTime_q};

   // overrun, lamps and redundancy copy
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         overrun_q <= 1'b0;
         faultLamp <= 1'b0;
         cpuFault <= 1'b0;
         redundancyCopyEn <= 1'b0;
         copyAreas <= `AREA_NONE;
         updateLamp <= 1'b0;
         batteryLamp <= 1'b0;
         batteryPrev_q <= 1'b0;
      end else begin
         overrun_q <= loadSum > {2'h0, taskCycle_q};
         faultLamp <= overrun_q;
         cpuFault <= overrun_q;
         // only a healthy master sends its areas across
         redundancyCopyEn <= redEnable_q && pinStable[4] && !overrun_q;
         copyAreas <= (redEnable_q && pinStable[4] && !overrun_q) ?
            `AREA_COPY : `AREA_NONE;
         updateLamp <= flashOn;
         batteryLamp <= pinStable[3] | flashOn;
         batteryPrev_q <= pinStable[3];
      end
   end

   // sticky events; a new event beats a clear in the same cycle
   always @* begin
      events = {`EV_W{1'b0}};
      events[`EV_HWRESET] = hwGesture;
      events[`EV_FACTORY] = factoryGesture;
      events[`EV_OVERRUN] = overrun_q && !faultLamp;
      events[`EV_BATTERY] = pinStable[3] && !batteryPrev_q;
      events[`EV_POWERUP] = retainRestore;
      irqClear = {`EV_W{1'b0}};
      if (doWrite && awAddr_q[7:0] == `REG_IRQ_CLEAR && wStrb_q[0]) begin
         irqClear = wData_q[`EV_W-1:0];
      end
   end
   assign irq = |(irqStatus_q & irqEnable_q);

   // write channel: address and data may arrive in either order
   assign s_axi_awready = !awHave_q && !s_axi_bvalid;
   assign s_axi_wready = !wHave_q && !s_axi_bvalid;
   assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 32'h00000000;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         redEnable_q <= 1'b0;
         progTime_q <= 16'h0000;
         ioTime_q <= 16'h0000;
         redTime_q <= 16'h0000;
         taskCycle_q <= 16'hffff;
         irqStatus_q <= {`EV_W{1'b0}};
         irqEnable_q <= {`EV_W{1'b0}};
      end else begin
         irqStatus_q <= (irqStatus_q & ~irqClear) | events;
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awAddr_q[7:0]) && awAddr_q[31:8] == 24'h0 ?
               `RESP_OKAY : `RESP_SLVERR;
            case (awAddr_q)
               {24'h0, `REG_CTRL}: redEnable_q <= wStrb_q[0] ? wData_q[0] : redEnable_q;
               {24'h0, `REG_PROG_TIME}:
                  progTime_q <= mergeBytes(progTime_q, wData_q, wStrb_q);
               {24'h0, `REG_IO_TIME}:
                  ioTime_q <= mergeBytes(ioTime_q, wData_q, wStrb_q);
               {24'h0, `REG_RED_TIME}:
                  redTime_q <= mergeBytes(redTime_q, wData_q, wStrb_q);
               {24'h0, `REG_TASK_CYCLE}:
                  taskCycle_q <= mergeBytes(taskCycle_q, wData_q, wStrb_q);
               {24'h0, `REG_IRQ_ENABLE}:
                  irqEnable_q <= wStrb_q[0] ? wData_q[`EV_W-1:0] : irqEnable_q;
               default: redEnable_q <= redEnable_q;
            endcase
         end
      end
   end

   // read channel: one read in flight, data from a register
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= isMapped(s_axi_araddr[7:0]) && s_axi_araddr[31:8] == 24'h0 ?
            `RESP_OKAY : `RESP_SLVERR;
         case (s_axi_araddr)
            {24'h0, `REG_CTRL}: s_axi_rdata <= {31'h0, redEnable_q};
            {24'h0, `REG_STATUS}: s_axi_rdata <= {21'h0, state_q, cpuFault,
               redundancyCopyEn, pinStable[4], pinStable[3], keyPos};
            {24'h0, `REG_PROG_TIME}: s_axi_rdata <= {16'h0, progTime_q};
            {24'h0, `REG_IO_TIME}: s_axi_rdata <= {16'h0, ioTime_q};
            {24'h0, `REG_RED_TIME}: s_axi_rdata <= {16'h0, redTime_q};
            {24'h0, `REG_TASK_CYCLE}: s_axi_rdata <= {16'h0, taskCycle_q};
            {24'h0, `REG_IRQ_STATUS}: s_axi_rdata <= {27'h0, irqStatus_q};
            {24'h0, `REG_IRQ_ENABLE}: s_axi_rdata <= {27'h0, irqEnable_q};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // key_switch_reset_control
`default_nettype wire

// ===== key_operator.sv
// operator key switch model: turns a position code into contact levels
`timescale 1ns/1ns
`default_nettype none
module key_operator (
   input wire logic [1:0] keyCmd,
   output var logic remotePosition,
   output var logic runPosition,
   output var logic programPosition
);
   // one contact closed per detent; code 0 is between detents, all open
   assign remotePosition = (keyCmd == 2'h1);
   assign runPosition = (keyCmd == 2'h2);
   assign programPosition = (keyCmd == 2'h3);
endmodule // key_operator
`default_nettype wire

// ===== key_switch_reset_control_checker.sv
// port assertions for the key switch reset control block
`timescale 1ns/1ns
`default_nettype none
`include "key_switch_reset_defs.vh"
module key_switch_reset_checker (
   input wire clk,
   input wire rst,
   input wire localHwReset,
   input wire mastershipRelease,
   input wire [5:0] areaInit,
   input wire retainRestore,
   input wire storageErase,
   input wire userFilesErase,
   input wire [5:0] copyAreas,
   input wire redundancyCopyEn,
   input wire updateLamp,
   input wire batteryLamp,
   input wire faultLamp,
   input wire cpuFault
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // sixteen cycles of local reset, then low again
   a_hwrst_width: assert property ($rose(localHwReset) |-> localHwReset[*8] ##1
      localHwReset[*8] ##1 !localHwReset) else $error("hw reset width wrong");
   a_master_handover: assert property (mastershipRelease |-> $rose(localHwReset))
      else $error("release without local reset");
   a_release_once: assert property (mastershipRelease |=> !mastershipRelease)
      else $error("release pulse too long");
   a_restore_areas: assert property (retainRestore |-> areaInit == `AREA_NO_R)
      else $error("power up areas wrong");
   a_factory_wipe: assert property (userFilesErase |-> areaInit == `AREA_ALL)
      else $error("factory areas wrong");
   a_clear_wipe: assert property (storageErase |-> areaInit == `AREA_ALL)
      else $error("clear areas wrong");
   a_lamps_together: assert property (updateLamp |-> batteryLamp)
      else $error("lamps not together");
   a_flash_restart: assert property ($fell(updateLamp) |-> ##[0:2] localHwReset)
      else $error("no restart after flash");
   a_fault_pair: assert property (faultLamp == cpuFault)
      else $error("fault lamp and fault differ");
   a_copy_stop: assert property (cpuFault |-> ##[0:2] !redundancyCopyEn)
      else $error("copy runs during fault");
   a_copy_areas: assert property (copyAreas == (redundancyCopyEn ? `AREA_COPY : `AREA_NONE))
      else $error("copy areas wrong");
endmodule // key_switch_reset_checker
bind key_switch_reset_control key_switch_reset_checker chk (.clk(clk), .rst(rst),
   .localHwReset(localHwReset), .mastershipRelease(mastershipRelease), .areaInit(areaInit),
   .retainRestore(retainRestore), .storageErase(storageErase), .userFilesErase(userFilesErase),
   .copyAreas(copyAreas), .redundancyCopyEn(redundancyCopyEn), .updateLamp(updateLamp),
   .batteryLamp(batteryLamp), .faultLamp(faultLamp), .cpuFault(cpuFault));
`default_nettype wire

// ===== key_switch_reset_control_bench.sv
// self-checking bench for the key switch reset control block
`timescale 1ns/1ns
`default_nettype none
`include "key_switch_reset_defs.vh"
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin errTotal++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module key_switch_reset_control_bench;
   logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdv;
   logic [1:0] keyCmd = 2'h1, rsp;
   logic batteryLowPin = 0, isMasterPin = 1, clrSeen = 0;
   wire awready, wready, bvalid, arready, rvalid, remotePosition, runPosition, programPosition;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire localHwReset, mastershipRelease, retainRestore, storageErase, userFilesErase;
   wire redundancyCopyEn, updateLamp, batteryLamp, faultLamp, cpuFault, irq;
   wire [5:0] areaInit, copyAreas;
   logic [5:0] areaSeen = 0, flagsSeen = 0;
   int errTotal = 0, numChecks = 0;
   typedef struct { logic [31:0] cmd; logic [5:0] area; logic [5:0] flags; } row_t;
   row_t rows[4] = '{'{32'h1, 6'h2f, 6'h00}, '{32'h2, 6'h3f, 6'h00},
      '{32'h4, 6'h00, 6'h00}, '{32'h8, 6'h3f, 6'h04}};
   key_switch_reset_control #(.GESTURE_CYCLES(200), .DEBOUNCE_CYCLES(4), .FLASH_CYCLES(20)) dut (
      .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .remotePosition(remotePosition), .runPosition(runPosition),
      .programPosition(programPosition), .batteryLowPin(batteryLowPin),
      .isMasterPin(isMasterPin), .localHwReset(localHwReset),
      .mastershipRelease(mastershipRelease), .areaInit(areaInit), .retainRestore(retainRestore),
      .storageErase(storageErase), .userFilesErase(userFilesErase), .copyAreas(copyAreas),
      .redundancyCopyEn(redundancyCopyEn), .updateLamp(updateLamp), .batteryLamp(batteryLamp),
      .faultLamp(faultLamp), .cpuFault(cpuFault), .irq(irq));
   key_operator op (.keyCmd(keyCmd), .remotePosition(remotePosition),
      .runPosition(runPosition), .programPosition(programPosition));
   // clock
   initial begin
      forever #20 clk = ~clk;
   end
   // sticky record of pulses, so checks do not hinge on exact pulse cycles
   always @(posedge clk) begin
      if (clrSeen) begin
         areaSeen <= 0;
         flagsSeen <= 0;
      end else begin
         areaSeen <= areaSeen | areaInit;
         flagsSeen <= flagsSeen | {mastershipRelease, localHwReset, userFilesErase,
            storageErase, retainRestore, updateLamp & batteryLamp};
      end
   end
   task automatic summarize();
      $display("checks %0d errors %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // readies are sampled at the falling edge, where they equal their value at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      logic ta, tw, tb;
      @(posedge clk);
      awaddr <= {24'h0, a}; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(negedge clk); ta = awready; tw = wready; tb = bvalid; rsp = bresp; n++;
         @(posedge clk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
      end while (!tb && n < 50);
      bready <= 0;
      if (!tb) begin errTotal++; summarize(); end
   endtask
   task automatic rd(input logic [7:0] a);
      int n = 0;
      logic ta, tr;
      @(posedge clk);
      araddr <= {24'h0, a}; arvalid <= 1; rready <= 1;
      do begin
         @(negedge clk); ta = arready; tr = rvalid; rdv = rdata; rsp = rresp; n++;
         @(posedge clk);
         if (ta) arvalid <= 0;
      end while (!tr && n < 50);
      rready <= 0;
      if (!tr) begin errTotal++; summarize(); end
   endtask
   task automatic clr();
      @(posedge clk); clrSeen <= 1;
      @(posedge clk); clrSeen <= 0;
   endtask
   // hold each position well past synchroniser plus debounce
   task automatic key(input logic [1:0] p);
      @(posedge clk); keyCmd <= p;
      repeat (12) @(posedge clk);
   endtask
   task automatic gest(input logic [1:0] mid);
      key(mid); key(2'h1); key(mid); key(2'h1);
   endtask
   task automatic waitHw();
      int n = 0;
      while (localHwReset !== 1'b1 && n < 300) begin @(posedge clk); n++; end
      if (n == 300) begin errTotal++; summarize(); end
      repeat (24) @(posedge clk);
   endtask
   // watchdog against any hang
   initial begin
      repeat (20000) @(posedge clk);
      errTotal++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      repeat (20) @(posedge clk);
      `CHK("powerup areas", 6'h2f, areaSeen)
      `CHK("powerup flags", 6'h02, flagsSeen)
      wr(`REG_IRQ_ENABLE, 32'h10);
      `CHK("irq powerup", 1'b1, irq)
      wr(`REG_IRQ_CLEAR, 32'h10);
      `CHK("irq cleared", 1'b0, irq)
      rd(8'h40);
      `CHK("unmapped", 34'h2_0000_0000, {rsp, rdv})
      foreach (rows[i]) begin
         clr(); wr(`REG_CMD, rows[i].cmd); repeat (4) @(posedge clk);
         `CHK("cmd areas", rows[i].area, areaSeen)
         `CHK("cmd flags", rows[i].flags, flagsSeen)
      end
      clr(); gest(2'h2); waitHw();
      `CHK("hw flags", 6'h30, flagsSeen)
      `CHK("run entry areas", 6'h1f, areaSeen)
      rd(`REG_IRQ_STATUS);
      `CHK("hw event masked", 2'h2, {rdv[`EV_HWRESET], irq})
      isMasterPin <= 0; repeat (12) @(posedge clk);
      clr(); gest(2'h3); waitHw();
      `CHK("factory flags", 6'h19, flagsSeen)
      `CHK("factory areas", 6'h3f, areaSeen)
      isMasterPin <= 1; // master again, so the copy checks below can see copying
      clr(); key(2'h2); repeat (250) @(posedge clk);
      key(2'h1); key(2'h2); key(2'h1); repeat (40) @(posedge clk);
      `CHK("late gesture", 1'b0, flagsSeen[4])
      wr(`REG_CTRL, 32'h1); repeat (4) @(posedge clk);
      `CHK("copy on", 7'h5f, {redundancyCopyEn, copyAreas})
      wr(`REG_PROG_TIME, 32'ha); wr(`REG_IO_TIME, 32'ha); wr(`REG_RED_TIME, 32'ha);
      wr(`REG_TASK_CYCLE, 32'h1e); repeat (4) @(posedge clk);
      `CHK("sum equal task", 3'b001, {faultLamp, cpuFault, redundancyCopyEn})
      wr(`REG_TASK_CYCLE, 32'h1d); repeat (4) @(posedge clk);
      `CHK("overrun", 3'b110, {faultLamp, cpuFault, redundancyCopyEn})
      batteryLowPin <= 1; repeat (12) @(posedge clk);
      `CHK("battery alarm", 1'b1, batteryLamp)
      // second power-up in mid-run: retained area reloaded, the rest initialised again
      clr(); rst <= 1; repeat (2) @(posedge clk);
      rst <= 0; repeat (20) @(posedge clk);
      `CHK("rerun areas", 6'h2f, areaSeen)
      `CHK("rerun flags", 6'h02, flagsSeen)
      summarize();
   end
endmodule // key_switch_reset_control_bench
`default_nettype wire
